// ===== cfrm_pkg.sv
// Constants, types and helpers shared by the configuration message responder
package cfrm_pkg;
   localparam logic [7:0] TOK_WRITE    = 8'hc0;
   localparam logic [7:0] TOK_READ     = 8'hc1;
   localparam logic [7:0] TOK_END      = 8'h01;
   localparam logic [7:0] TOK_ACK      = 8'h03;
   localparam logic [7:0] TOK_NAK      = 8'h04;
   localparam logic [7:0] NO_REPLY_LOW = 8'hff;
   localparam logic [7:0] PS_RES_TYPE  = 8'h0b;
   localparam int         PS_SHIFT     = 8;
   localparam logic [2:0] ID_LAST      = 3'h2;
   localparam logic [2:0] REG_LAST     = 3'h1;
   localparam logic [2:0] DATA_LAST    = 3'h3;
   localparam logic [2:0] STEP_HEAD    = 3'h0;
   localparam logic [2:0] STEP_LASTB   = 3'h4;
   localparam logic [2:0] STEP_END     = 3'h5;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_ID    = 4'b0001,
      ST_REGN  = 4'b0010,
      ST_DATA  = 4'b0011,
      ST_TAIL  = 4'b0100,
      ST_DRAIN = 4'b0101,
      ST_ACC   = 4'b0110,
      ST_REPLY = 4'b0111,
      ST_WAIT  = 4'b1000
   } cfrm_state_t;

   // Most significant byte arrives first, so earlier bytes shift upward
   function automatic logic [31:0] cfrm_shift_in(input logic [31:0] w, input logic [7:0] b);
      return {w[23:0], b};
   endfunction

   // Byte idx 0 is the most significant one
   function automatic logic [7:0] cfrm_byte_of(input logic [31:0] w, input logic [1:0] idx);
      logic [31:0] s;
      s = w << {idx, 3'b000};
      return s[31:24];
   endfunction

   function automatic logic [31:0] cfrm_ps_res_id(input logic [15:0] num);
      return ({16'h0000, num} << PS_SHIFT) | {24'h000000, PS_RES_TYPE};
   endfunction
endpackage

// ===== cfrm_reply_if.sv
// Carrier between the request parser and the reply sender
`timescale 1ns/1ps
interface cfrm_reply_if;
   logic        start;
   logic        okay;
   logic        withData;
   logic [31:0] data;
   logic [23:0] dest;
   logic        busy;
   modport req  (output start, output okay, output withData, output data, output dest,
                 input busy);
   modport xmit (input start, input okay, input withData, input data, input dest,
                 output busy);
endinterface

// ===== cfrm_reply_tx.sv
// Reply sender: status token, optional data word, closing token
`timescale 1ns/1ps
module cfrm_reply_tx (
   input  wire logic     clk_sys,
   input  wire logic     sys_rst,
   cfrm_reply_if.xmit    rep,
   output logic          txValid,
   output logic          txCtrl,
   output logic [7:0]    txData,
   output logic [23:0]   txDest,
   input  wire logic     txReady
);
   import cfrm_pkg::*;

   typedef struct packed {
      logic        busy;
      logic [2:0]  step;
      logic        valid;
      logic        ctrl;
      logic [7:0]  data;
      logic [23:0] dest;
      logic        withWord;
      logic [31:0] word;
   } cfrm_tx_t;

   cfrm_tx_t q;
   cfrm_tx_t d;

   always_comb begin
      d = q;
      if (!q.busy && rep.start) begin
         d.busy     = 1'b1;
         d.step     = STEP_HEAD;
         d.valid    = 1'b1;
         d.ctrl     = 1'b1;
         d.data     = rep.okay ? TOK_ACK : TOK_NAK;
         d.dest     = rep.dest;
         d.withWord = rep.okay && rep.withData;
         d.word     = rep.data;
      end else if (q.valid && txReady) begin
         if (q.step == STEP_END) begin
            d.valid = 1'b0;
            d.busy  = 1'b0;
         end else if ((q.step == STEP_HEAD && !q.withWord) || q.step == STEP_LASTB) begin
            d.step = STEP_END;
            d.ctrl = 1'b1;
            d.data = TOK_END;
         end else begin
            d.step = q.step + 3'h1;
            d.ctrl = 1'b0;
            d.data = cfrm_byte_of(q.word, q.step[1:0]);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign rep.busy = q.busy;
   assign txValid  = q.valid;
   assign txCtrl   = q.ctrl;
   assign txData   = q.data;
   assign txDest   = q.dest;
endmodule

// ===== cfrm_responder.sv
// Configuration register message responder: parses requests, runs the access, replies
`timescale 1ns/1ps

// Summary of operation
// - A write request is token 192, a 3-byte reply id, a 2-byte register number, 4 data bytes, token 1.
// - A write is answered with tokens 3 then 1 on success, or tokens 4 then 1 on failure.
// - A read request is token 192+1, a 3-byte reply id, a 2-byte register number and token 1.
// - A read is answered with token 3, four data bytes and token 1, or tokens 4 then 1.
// - The reply id is the top 24 bits of the reply channel-end, node plus channel number.
// - A write whose reply id has its low byte all ones gets no reply at all.
// - Every multi-byte field travels most significant byte first.
// - A status register resource id is the register number shifted left 8 and ORed with 0x0b.
module cfrm_responder (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        rxValid,
   input  wire logic        rxCtrl,
   input  wire logic [7:0]  rxData,
   output logic             rxReady,
   output logic             txValid,
   output logic             txCtrl,
   output logic [7:0]       txData,
   output logic [23:0]      txDest,
   input  wire logic        txReady,
   output logic             regReq,
   output logic             regWrite,
   output logic [15:0]      regAddr,
   output logic [31:0]      regWdata,
   output logic [31:0]      regResId,
   input  wire logic        regAck,
   input  wire logic        regErr,
   input  wire logic [31:0] regRdata
);
   import cfrm_pkg::*;

   typedef struct packed {
      cfrm_state_t st;
      logic [2:0]  cnt;
      logic        isWrite;
      logic        idDone;
      logic [23:0] dest;
      logic [15:0] regNum;
      logic [31:0] wdata;
      logic        rxReady;
      logic        regReq;
      logic [31:0] resId;
      logic        start;
      logic        okay;
      logic [31:0] rdata;
   } cfrm_rsp_t;

   cfrm_rsp_t   q;
   cfrm_rsp_t   d;
   logic        rxFire;
   logic        isEnd;
   logic        tokWrite;
   logic        tokRead;
   logic        bodyBad;
   logic [31:0] destIn;
   logic [31:0] regIn;

   cfrm_reply_if rep ();

   // One decode for every control-token test on the incoming link
   function automatic logic cfrm_tok_is(input logic c, input logic [7:0] v, input logic [7:0] t);
      return c && v == t;
   endfunction

   // Parser states that take tokens; replies never overlap requests
   function automatic logic cfrm_parsing(input cfrm_state_t s);
      case (s)
         ST_IDLE, ST_ID, ST_REGN, ST_DATA, ST_TAIL, ST_DRAIN: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction

   assign rxFire   = rxValid && q.rxReady;
   assign isEnd    = cfrm_tok_is(rxCtrl, rxData, TOK_END);
   assign tokWrite = cfrm_tok_is(rxCtrl, rxData, TOK_WRITE);
   assign tokRead  = cfrm_tok_is(rxCtrl, rxData, TOK_READ);
   // Inside a body a control token is legal only as the closing one in the tail
   assign bodyBad  = rxFire && rxCtrl && !(q.st == ST_TAIL && isEnd);
   // Shift paths for fields that arrive most significant byte first
   assign destIn   = cfrm_shift_in({8'h00, q.dest}, rxData);
   assign regIn    = cfrm_shift_in({16'h0000, q.regNum}, rxData);

   always_comb begin
      d = q;
      case (q.st)
         ST_IDLE: begin
            if (rxFire) begin
               d.cnt    = 3'h0;
               d.idDone = 1'b0;
               d.okay   = 1'b1;
               if (tokWrite) begin
                  d.isWrite = 1'b1;
                  d.st      = ST_ID;
               end else if (tokRead) begin
                  d.isWrite = 1'b0;
                  d.st      = ST_ID;
               end else if (!isEnd) begin
                  // Stray traffic: no reply id known, so swallow it silently
                  d.st = ST_DRAIN;
               end
            end
         end

         ST_ID, ST_REGN, ST_DATA, ST_TAIL: begin
            if (bodyBad) begin
               // Malformed body: fail once the closing token shows up
               d.okay = 1'b0;
               d.st   = isEnd ? (q.idDone ? ST_REPLY : ST_IDLE) : ST_DRAIN;
            end else if (rxFire && q.st == ST_ID) begin
               d.dest = destIn[23:0];
               d.cnt  = q.cnt + 3'h1;
               if (q.cnt == ID_LAST) begin
                  d.idDone = 1'b1;
                  d.cnt    = 3'h0;
                  d.st     = ST_REGN;
               end
            end else if (rxFire && q.st == ST_REGN) begin
               d.regNum = regIn[15:0];
               d.cnt    = q.cnt + 3'h1;
               if (q.cnt == REG_LAST) begin
                  d.cnt = 3'h0;
                  d.st  = q.isWrite ? ST_DATA : ST_TAIL;
               end
            end else if (rxFire && q.st == ST_DATA) begin
               d.wdata = cfrm_shift_in(q.wdata, rxData);
               d.cnt   = q.cnt + 3'h1;
               if (q.cnt == DATA_LAST) begin
                  d.st = ST_TAIL;
               end
            end else if (rxFire && q.st == ST_TAIL) begin
               if (isEnd) begin
                  d.regReq = 1'b1;
                  d.resId  = cfrm_ps_res_id(q.regNum);
                  d.st     = ST_ACC;
               end else begin
                  d.okay = 1'b0;
                  d.st   = ST_DRAIN;
               end
            end
         end

         ST_DRAIN: begin
            if (rxFire && isEnd) begin
               d.st = (q.idDone && !q.okay) ? ST_REPLY : ST_IDLE;
            end
         end

         ST_ACC: begin
            // Bank holds regAck until it has decided; regErr marks absent or read-only
            if (regAck) begin
               d.regReq = 1'b0;
               d.okay   = !regErr;
               d.rdata  = regRdata;
               d.st     = ST_REPLY;
            end
         end

         ST_REPLY: begin
            // Suppression covers writes only; a read always answers
            if (q.isWrite && q.dest[7:0] == NO_REPLY_LOW) begin
               d.st = ST_IDLE;
            end else if (!rep.busy) begin
               d.start = 1'b1;
               d.st    = ST_WAIT;
            end
         end

         ST_WAIT: begin
            d.start = 1'b0;
            if (!q.start && !rep.busy) begin
               d.st = ST_IDLE;
            end
         end

         default: begin
            d.st = ST_IDLE;
         end
      endcase
      d.rxReady = cfrm_parsing(d.st);
   end

   // Reset leaves the parser open for the first token
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q         <= '0;
         q.st      <= ST_IDLE;
         q.rxReady <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign rep.start    = q.start;
   assign rep.okay     = q.okay;
   assign rep.withData = !q.isWrite;
   assign rep.data     = q.rdata;
   assign rep.dest     = q.dest;

   // Sender runs apart, so a stalled far end only parks the parser in ST_WAIT
   cfrm_reply_tx u_tx (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .rep     (rep.xmit),
      .txValid (txValid),
      .txCtrl  (txCtrl),
      .txData  (txData),
      .txDest  (txDest),
      .txReady (txReady)
   );

   assign rxReady  = q.rxReady;
   assign regReq   = q.regReq;
   assign regWrite = q.isWrite;
   assign regAddr  = q.regNum;
   assign regWdata = q.wdata;
   assign regResId = q.resId;
endmodule

// ===== cfrm_far_end.sv
// Far channel-end model: takes reply tokens, stalling at random
`timescale 1ns/1ps
module cfrm_far_end (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        txValid,
   input  wire logic        txCtrl,
   input  wire logic [7:0]  txData,
   input  wire logic [23:0] txDest,
   output logic             txReady
);
   logic [32:0] got[$];
   logic [15:0] rnd = 16'hace1;
   // Stalls about half the time so that held tokens get exercised
   always @(negedge clk_sys) begin
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      txReady = rnd[0];
   end
   // Keeps arrival order, which carries the byte order
   always @(posedge clk_sys)
      if (!sys_rst && txValid && txReady) got.push_back({txDest, txCtrl, txData});
endmodule

// ===== cfrm_responder_chk.sv
// Port checker for the configuration message responder
`timescale 1ns/1ps
module cfrm_responder_chk (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic        rxReady,
   input wire logic        txValid,
   input wire logic        txCtrl,
   input wire logic [7:0]  txData,
   input wire logic [23:0] txDest,
   input wire logic        txReady,
   input wire logic        regReq,
   input wire logic        regWrite,
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regResId,
   input wire logic        regAck,
   input wire logic        regErr
);
   import cfrm_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_req_hold: assert property (regReq && !regAck |=> regReq && $stable(regAddr))
      else $error("access dropped early");
   chk_req_drop: assert property (regReq && regAck |=> !regReq)
      else $error("access not ended");
   chk_res_id: assert property (regReq |-> regResId == ({16'h0000, regAddr} << 8 | 32'h0b))
      else $error("bad resource id");
   chk_rx_busy: assert property (regReq |-> !rxReady)
      else $error("taking tokens during access");
   chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable({txCtrl, txData, txDest}))
      else $error("token changed before taken");
   chk_nak_end: assert property (txValid && txReady && txCtrl && txData == TOK_NAK
      |=> txValid && txCtrl && txData == TOK_END)
      else $error("failure not closed");
   chk_read_ack: assert property (regReq && regAck && !regErr && !regWrite
      |-> ##[1:4] txValid && txCtrl && txData == TOK_ACK)
      else $error("read success not sent");
   chk_read_nak: assert property (regReq && regAck && regErr && !regWrite
      |-> ##[1:4] txValid && txCtrl && txData == TOK_NAK)
      else $error("read failure not sent");
endmodule
bind cfrm_responder cfrm_responder_chk chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .rxReady(rxReady), .txValid(txValid), .txCtrl(txCtrl), .txData(txData), .txDest(txDest),
   .txReady(txReady), .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr),
   .regResId(regResId), .regAck(regAck), .regErr(regErr));

// ===== test_config_register_msg_responder.sv
// Self-checking bench for the configuration message responder
`timescale 1ns/1ps
module test_config_register_msg_responder;
   import cfrm_pkg::*;
   logic clk_sys = 0, sys_rst = 1, rxValid = 0, rxCtrl = 0, regAck = 0, regErr = 0;
   logic [7:0] rxData = 0, txData;
   logic [31:0] regRdata = 0, regWdata, regResId, curD, rb = 32'h7800b896;
   logic [15:0] regAddr, curA;
   logic [23:0] txDest;
   logic rxReady, txValid, txCtrl, txReady, regReq, regWrite, curW;
   int miscompares = 0, n_compared = 0;
   always #12.5 clk_sys = ~clk_sys;
   cfrm_responder DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .rxValid(rxValid),
      .rxCtrl(rxCtrl), .rxData(rxData), .rxReady(rxReady), .txValid(txValid),
      .txCtrl(txCtrl), .txData(txData), .txDest(txDest), .txReady(txReady),
      .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
      .regResId(regResId), .regAck(regAck), .regErr(regErr), .regRdata(regRdata));
   cfrm_far_end far (.clk_sys(clk_sys), .sys_rst(sys_rst), .txValid(txValid),
      .txCtrl(txCtrl), .txData(txData), .txDest(txDest), .txReady(txReady));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] rd(input logic [15:0] a);
      return {a, ~a};
   endfunction
   // Access as the bank sees it; write data only matters on a write
   function automatic logic [48:0] acc(input logic w, input logic [15:0] a, input logic [31:0] v);
      return {w, a, w ? v : 32'h0};
   endfunction
   // Fabric stand-in: only tile (c20c) or node (c30c) bank addresses are delivered
   function automatic logic routed(input logic [31:0] dst);
      return dst[15:0] == 16'hc20c || dst[15:0] == 16'hc30c;
   endfunction
   // Top half of the register space plays the absent or read-only part
   function automatic logic [32:0] tok(logic w, logic [23:0] id, logic [15:0] a, int i);
      logic [31:0] r;
      r = rd(a);
      if (a[15]) return {id, 1'b1, i ? TOK_END : TOK_NAK};
      if (w || i == 5) return {id, 1'b1, i ? TOK_END : TOK_ACK};
      return i ? {id, 1'b0, r[8*(4-i) +: 8]} : {id, 1'b1, TOK_ACK};
   endfunction
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Offers one token and holds it until taken
   task automatic put(input logic c, input logic [7:0] d);
      int t;
      rxValid <= 1;
      rxCtrl <= c;
      rxData <= d;
      for (t = 0; t < 500 && !rxReady; t++) @(negedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic req(logic w, logic [23:0] id, logic [15:0] a, logic [31:0] d);
      int k, n;
      curW = w;
      curA = a;
      curD = d;
      put(1, w ? TOK_WRITE : TOK_READ);
      for (k = 2; k >= 0; k--) put(0, id[8*k +: 8]);
      for (k = 1; k >= 0; k--) put(0, a[8*k +: 8]);
      if (w) for (k = 3; k >= 0; k--) put(0, d[8*k +: 8]);
      put(1, TOK_END);
      rxValid <= 0;
      repeat (3) @(negedge clk_sys);
      for (k = 0; k < 500 && !rxReady; k++) @(negedge clk_sys);
      n = (w && id[7:0] == NO_REPLY_LOW) ? 0 : (!w && !a[15]) ? 6 : 2;
      cmp(far.got.size(), n);
      for (k = 0; k < n; k++) cmp(far.got[k], tok(w, id, a, k));
      far.got.delete();
   endtask
   // Stray byte in idle is swallowed; a byte where the closing token belongs fails the read
   task automatic bad(input logic [23:0] id);
      int k;
      put(0, 8'h5a);
      put(1, TOK_END);
      put(1, TOK_READ);
      for (k = 2; k >= 0; k--) put(0, id[8*k +: 8]);
      put(0, 8'h80);
      put(0, 8'h01);
      put(0, 8'h5a);
      put(1, TOK_END);
      rxValid <= 0;
      repeat (3) @(negedge clk_sys);
      for (k = 0; k < 500 && !rxReady; k++) @(negedge clk_sys);
      cmp(far.got.size(), 2);
      for (k = 0; k < 2; k++) cmp(far.got[k], tok(0, id, 16'h8000, k));
      far.got.delete();
   endtask
   // Register bank: random latency, answers on what the access carries
   always @(negedge clk_sys) begin
      rb = lfsr(rb);
      regAck <= regReq && !regAck && rb[1];
      regErr <= regAddr[15];
      regRdata <= rd(regAddr);
   end
   always @(posedge clk_sys)
      if (regReq && regAck) begin
         cmp(acc(regWrite, regAddr, regWdata), acc(curW, curA, curD));
         cmp(regResId, {8'h00, curA, 8'h0b});
      end
   initial begin
      logic [31:0] r;
      logic [31:0] dst;
      int i;
      r = 32'h7800b896;
      repeat (5) @(negedge clk_sys);
      cmp({rxReady, txValid, regReq}, 3'b100);
      sys_rst = 0;
      req(1, 24'h1234ff, 16'h0002, 32'hdeadbeef);
      req(1, 24'h5678ff, 16'h8003, 32'h0);
      req(0, 24'h1234ff, 16'h8001, 32'h0);
      req(1, 24'h00a1c2, 16'hffff, 32'h1);
      req(0, 24'hfedcba, 16'h7fff, 32'h0);
      bad(24'h3c5a01);
      for (i = 0; i < 32; i++) begin
         r = lfsr(r);
         // Some traffic aims elsewhere on the fabric and never reaches the block
         dst = {r[15:0], r[1] ? (r[2] ? 16'hc30c : 16'hc20c) : r[31:16]};
         if (routed(dst)) req(r[0], r[31:8], r[23:8], lfsr(r));
      end
      end_of_test;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      end_of_test;
   end
endmodule
